// [ccor_pkg.sv]
// Package for the clock and output override register block.
// Assumes an 8-bit register port with a 7-bit address from the serial control port.
package ccor_pkg;
   localparam logic [6:0] ADDR_OSCILLATOR_BIAS_LEVEL  = 7'h3f;
   localparam logic [6:0] ADDR_PREEMPH   = 7'h48;
   localparam logic [6:0] ADDR_TRIG_CTRL = 7'h57;
   localparam logic [6:0] ADDR_PIN_OVR   = 7'h58;
   localparam logic [7:0] RST_OSCILLATOR_BIAS_LEVEL   = 8'h4f;
   localparam logic [7:0] RST_PREEMPH    = 8'h00;
   localparam logic [7:0] RST_TRIG_CTRL  = 8'h00;
   localparam logic [7:0] RST_PIN_OVR    = 8'h00;
   localparam logic [6:0] OSCILLATOR_BIAS_LEVEL_RECOMMENDED = 7'h4a;
   localparam int BIAS_MSB   = 6;
   localparam int PE_MSB     = 3;
   localparam int TRIG_EN    = 7;
   localparam int TRIG_MSB   = 2;
   localparam int OVR_EN     = 7;
   localparam int REFD_LSB   = 4;
   localparam int REFC_LSB   = 2;
   localparam int SE_BIT     = 1;
   localparam int PLLEN_BIT  = 0;
   localparam int DIV16_BIT  = 3;
   localparam int DIV32_BIT  = 4;
   localparam int DIV64_BIT  = 5;
   localparam logic [2:0] TRIG_UI16 = 3'h0;
   localparam logic [2:0] TRIG_UI32 = 3'h1;
   localparam logic [2:0] TRIG_UI64 = 3'h2;
   localparam logic [2:0] TRIG_TSTAMP = 3'h3;
   localparam logic [1:0] REF_OFF  = 2'h0;
   localparam logic [1:0] REF_DIV1 = 2'h1;
   localparam logic [1:0] REF_DIV2 = 2'h2;
   localparam logic [1:0] REF_DIV4 = 2'h3;

   typedef struct packed {
      logic       write;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ccor_req_s;

   typedef struct packed {
      logic       pll_enable;
      logic       single_ended_ref;
      logic [1:0] refout_c_select;
      logic [1:0] refout_d_select;
   } ccor_pll_ctrl_s;
endpackage

// [ccor_regs.sv]
// Clock, trigger-output and PLL pin-override configuration registers.
// Assumes a serial control port front end delivering one-cycle address and data requests; this block decodes the address.
`timescale 1ns/1ps
`default_nettype none
module ccor_regs (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     clk_en,
   input  wire ccor_pkg::ccor_req_s      req,
   input  wire logic                     req_valid,
   output logic [7:0]                    rdata,
   input  wire logic                     pll_enable_pin,
   input  wire logic                     ref_select_pin,
   input  wire logic                     clock_config_pin_a,
   input  wire logic                     clock_config_pin_b,
   input  wire logic                     receiver_reference_clock,
   input  wire logic                     timestamp_input,
   input  wire logic                     serializer_reinit,
   input  wire logic                     pll_reference_clock,
   output logic [3:0]                    lane_preemphasis,
   output logic [6:0]                    oscillator_bias_level,
   output logic                          trigger_output_pin,
   output logic                          trigger_output_enable,
   output ccor_pkg::ccor_pll_ctrl_s      pll_ctrl,
   output logic                          divided_ref_out_c,
   output logic                          divided_ref_out_d
);
   logic [7:0] bias_q, pe_q, trig_q, ovr_q;
   logic [7:0] rdata_d;
   logic       trig_q_out, ts_q;
   logic [5:0] rx_div_q;
   logic [1:0] ref_div_q;
   logic       wr;
   logic [2:0] trig_sel;
   logic       trig_raw;
   logic [1:0] pin_sel;
   ccor_pkg::ccor_pll_ctrl_s pll_d;

   assign wr = req_valid && req.write;

   always_ff @(posedge clk) begin
      if (rst) begin
         bias_q <= ccor_pkg::RST_OSCILLATOR_BIAS_LEVEL;
         pe_q   <= ccor_pkg::RST_PREEMPH;
         trig_q <= ccor_pkg::RST_TRIG_CTRL;
         ovr_q  <= ccor_pkg::RST_PIN_OVR;
      end else if (clk_en && wr) begin
         // Reserved bits are stored as written; the host keeps them at reset value.
         unique case (req.addr)
            ccor_pkg::ADDR_OSCILLATOR_BIAS_LEVEL:  bias_q <= req.wdata;
            ccor_pkg::ADDR_PREEMPH:   pe_q   <= req.wdata;
            ccor_pkg::ADDR_TRIG_CTRL: trig_q <= req.wdata;
            ccor_pkg::ADDR_PIN_OVR:   ovr_q  <= req.wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      unique case (req.addr)
         ccor_pkg::ADDR_OSCILLATOR_BIAS_LEVEL:  rdata_d = bias_q;
         ccor_pkg::ADDR_PREEMPH:   rdata_d = pe_q;
         ccor_pkg::ADDR_TRIG_CTRL: rdata_d = trig_q;
         ccor_pkg::ADDR_PIN_OVR:   rdata_d = ovr_q;
         default:                  rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (clk_en && req_valid && !req.write) begin
         rdata <= rdata_d;
      end
   end

   assign oscillator_bias_level = bias_q[ccor_pkg::BIAS_MSB:0];
   assign lane_preemphasis      = pe_q[ccor_pkg::PE_MSB:0];

   // Trigger output path.
   assign trigger_output_enable = trig_q[ccor_pkg::TRIG_EN];
   assign trig_sel = trig_q[ccor_pkg::TRIG_MSB:0];

   // The divider restarts with the serializer, so the trigger clock glitches then.
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_div_q <= 6'h00;
         ts_q     <= 1'b0;
      end else if (clk_en) begin
         if (serializer_reinit || !trigger_output_enable) begin
            rx_div_q <= 6'h00;
         end else if (receiver_reference_clock) begin
            rx_div_q <= rx_div_q + 6'h01;
         end
         ts_q <= timestamp_input;
      end
   end

   always_comb begin
      unique case (trig_sel)
         ccor_pkg::TRIG_UI16:   trig_raw = rx_div_q[ccor_pkg::DIV16_BIT];
         ccor_pkg::TRIG_UI32:   trig_raw = rx_div_q[ccor_pkg::DIV32_BIT];
         ccor_pkg::TRIG_UI64:   trig_raw = rx_div_q[ccor_pkg::DIV64_BIT];
         ccor_pkg::TRIG_TSTAMP: trig_raw = ts_q;
         default:               trig_raw = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trig_q_out <= 1'b0;
      end else if (clk_en) begin
         trig_q_out <= trigger_output_enable && trig_raw;
      end
   end
   assign trigger_output_pin = trig_q_out;

   // PLL control source: pins or register values; the D output select is forced off whenever the C select is off.
   assign pin_sel = {clock_config_pin_b, clock_config_pin_a};
   always_comb begin
      if (ovr_q[ccor_pkg::OVR_EN]) begin
         pll_d.pll_enable       = ovr_q[ccor_pkg::PLLEN_BIT];
         pll_d.single_ended_ref = ovr_q[ccor_pkg::SE_BIT];
         pll_d.refout_c_select  = ovr_q[ccor_pkg::REFC_LSB +: 2];
         pll_d.refout_d_select  = ovr_q[ccor_pkg::REFD_LSB +: 2];
      end else begin
         pll_d.pll_enable       = pll_enable_pin;
         pll_d.single_ended_ref = ref_select_pin;
         pll_d.refout_c_select  = pin_sel;
         pll_d.refout_d_select  = pin_sel;
      end
      if (pll_d.refout_c_select == ccor_pkg::REF_OFF) begin
         pll_d.refout_d_select = ccor_pkg::REF_OFF;
      end
   end
   assign pll_ctrl = pll_d;

   // Reference divider shared by both outputs.
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_div_q <= 2'h0;
      end else if (clk_en && pll_reference_clock) begin
         ref_div_q <= ref_div_q + 2'h1;
      end
   end

   function automatic logic ref_out(input logic [1:0] sel, input logic refc,
                                    input logic [1:0] div);
      unique case (sel)
         ccor_pkg::REF_OFF:  ref_out = 1'b0;
         ccor_pkg::REF_DIV1: ref_out = refc;
         ccor_pkg::REF_DIV2: ref_out = div[0];
         ccor_pkg::REF_DIV4: ref_out = div[1];
      endcase
   endfunction

   assign divided_ref_out_c = ref_out(pll_d.refout_c_select, pll_reference_clock, ref_div_q);
   assign divided_ref_out_d = ref_out(pll_d.refout_d_select, pll_reference_clock, ref_div_q);

   // Register side: reset values, write effects and the clock-enable freeze.
   bias_reset_a: assert property (@(posedge clk)
      rst
      |=> oscillator_bias_level == ccor_pkg::RST_OSCILLATOR_BIAS_LEVEL[ccor_pkg::BIAS_MSB:0])
      else $error("bias reset value wrong");

   bias_write_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && wr && req.addr == ccor_pkg::ADDR_OSCILLATOR_BIAS_LEVEL
      |=> oscillator_bias_level == $past(req.wdata[ccor_pkg::BIAS_MSB:0]))
      else $error("bias write not stored");

   preemph_global_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && wr && req.addr == ccor_pkg::ADDR_PREEMPH
      |=> lane_preemphasis == $past(req.wdata[ccor_pkg::PE_MSB:0]))
      else $error("preemphasis write not applied");

   preemph_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(clk_en && wr && req.addr == ccor_pkg::ADDR_PREEMPH)
      |=> $stable(lane_preemphasis))
      else $error("preemphasis changed without write");

   freeze_regs_a: assert property (@(posedge clk) disable iff (rst)
      !clk_en
      |=> $stable(bias_q) && $stable(pe_q) && $stable(trig_q) && $stable(ovr_q))
      else $error("register changed while frozen");

   read_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(clk_en && req_valid && !req.write)
      |=> $stable(rdata))
      else $error("read data changed without read");

   read_ovr_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && req_valid && !req.write && req.addr == ccor_pkg::ADDR_PIN_OVR
      |=> rdata == $past(ovr_q))
      else $error("override read back wrong");

   // Trigger side: the divider only runs while enabled, so a disabled output stays quiet.
   trig_write_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && wr && req.addr == ccor_pkg::ADDR_TRIG_CTRL
      |=> trigger_output_enable == $past(req.wdata[ccor_pkg::TRIG_EN]))
      else $error("trigger enable write not applied");

   trig_off_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && !trigger_output_enable
      |=> !trigger_output_pin)
      else $error("trigger active while disabled");

   div_idle_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && !trigger_output_enable
      |=> rx_div_q == '0)
      else $error("trigger divider runs while disabled");

   div_count_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && trigger_output_enable && !serializer_reinit && receiver_reference_clock
      |=> rx_div_q == $past(rx_div_q) + 6'h01)
      else $error("trigger divider not counting");

   trig_ui16_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && trigger_output_enable && trig_sel == ccor_pkg::TRIG_UI16
      |=> trigger_output_pin == $past(rx_div_q[ccor_pkg::DIV16_BIT]))
      else $error("16 UI trigger clock wrong");

   trig_ui32_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && trigger_output_enable && trig_sel == ccor_pkg::TRIG_UI32
      |=> trigger_output_pin == $past(rx_div_q[ccor_pkg::DIV32_BIT]))
      else $error("32 UI trigger clock wrong");

   trig_ui64_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && trigger_output_enable && trig_sel == ccor_pkg::TRIG_UI64
      |=> trigger_output_pin == $past(rx_div_q[ccor_pkg::DIV64_BIT]))
      else $error("64 UI trigger clock wrong");

   trig_ts_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && trigger_output_enable && trig_sel == ccor_pkg::TRIG_TSTAMP
      |=> trigger_output_pin == $past(ts_q))
      else $error("trigger timestamp path wrong");

   trig_rsvd_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && trig_sel > ccor_pkg::TRIG_TSTAMP
      |=> !trigger_output_pin)
      else $error("reserved trigger mode drives output");

   reinit_clear_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && serializer_reinit
      |=> rx_div_q == '0)
      else $error("divider not restarted");

   // PLL control source and the divided reference outputs.
   pin_mode_a: assert property (@(posedge clk) disable iff (rst)
      !ovr_q[ccor_pkg::OVR_EN]
      |-> pll_ctrl.pll_enable == pll_enable_pin
          && pll_ctrl.single_ended_ref == ref_select_pin
          && pll_ctrl.refout_c_select == {clock_config_pin_b, clock_config_pin_a})
      else $error("pin mode not followed");

   ovr_mode_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q[ccor_pkg::OVR_EN]
      |-> pll_ctrl.pll_enable == ovr_q[ccor_pkg::PLLEN_BIT]
          && pll_ctrl.single_ended_ref == ovr_q[ccor_pkg::SE_BIT])
      else $error("override values not used");

   ovr_csel_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q[ccor_pkg::OVR_EN]
      |-> pll_ctrl.refout_c_select == ovr_q[ccor_pkg::REFC_LSB +: 2])
      else $error("c output mode not taken from register");

   ovr_dsel_a: assert property (@(posedge clk) disable iff (rst)
      ovr_q[ccor_pkg::OVR_EN] && pll_ctrl.refout_c_select != ccor_pkg::REF_OFF
      |-> pll_ctrl.refout_d_select == ovr_q[ccor_pkg::REFD_LSB +: 2])
      else $error("d output mode not taken from register");

   d_needs_c_a: assert property (@(posedge clk) disable iff (rst)
      pll_ctrl.refout_c_select == ccor_pkg::REF_OFF
      |-> !divided_ref_out_d)
      else $error("d output without c");

   refc_off_a: assert property (@(posedge clk) disable iff (rst)
      pll_ctrl.refout_c_select == ccor_pkg::REF_OFF
      |-> !divided_ref_out_c)
      else $error("c output runs while off");

   ref_div1_a: assert property (@(posedge clk) disable iff (rst)
      pll_ctrl.refout_c_select == ccor_pkg::REF_DIV1
      |-> divided_ref_out_c == pll_reference_clock)
      else $error("c output not the reference");

   ref_count_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && pll_reference_clock
      |=> ref_div_q == $past(ref_div_q) + 2'h1)
      else $error("reference divider not counting");

   ovr_write_a: assert property (@(posedge clk) disable iff (rst)
      clk_en && wr && req.addr == ccor_pkg::ADDR_PIN_OVR && req.wdata[ccor_pkg::OVR_EN]
      |=> pll_ctrl.pll_enable == $past(req.wdata[ccor_pkg::PLLEN_BIT]))
      else $error("override write not effective");
endmodule
`default_nettype wire

// [ccor_host.sv]
// Host model that issues register accesses to the configuration block.
// Assumes the bench calls its tasks; requests change 1 ns after clk rises.
`timescale 1ns/1ps
`default_nettype none
module ccor_host (
   input  wire logic           clk,
   output ccor_pkg::ccor_req_s req,
   output logic                req_valid,
   input  wire logic [7:0]     rdata
);
   initial begin
      req = '0;
      req_valid = 1'b0;
   end
   // Callers keep reserved bits at zero; the bench writes bias after reset with the PLL enable pin high.
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      req = '{write: w, addr: a, wdata: d};
      req_valid = 1'b1;
      @(posedge clk) #1;
      req_valid = 1'b0;
   endtask
   // The extra cycle lets a write reach the outputs before anyone looks.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
      @(posedge clk) #1;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      acc(1'b0, a, 8'h00);
      @(posedge clk) #1;
      d = rdata;
   endtask
endmodule
`default_nettype wire

// [ccor_regs_test.sv]
// Self-checking bench for the clock and output override registers.
// Assumes the host model supplies accesses; clk runs at 10 MHz.
`timescale 1ns/1ps
`default_nettype none
module ccor_regs_test;
   localparam logic [6:0] A_TRG = ccor_pkg::ADDR_TRIG_CTRL;
   localparam logic [6:0] A_OVR = ccor_pkg::ADDR_PIN_OVR;
   localparam logic [6:0] A_PE  = ccor_pkg::ADDR_PREEMPH;
   logic clk = 0, rst = 1, clk_en = 1, en_p = 1, se_p = 0, cfg_a = 0, cfg_b = 1;
   logic rx = 1, ts = 0, reinit = 0, pref = 0, trig, trig_en, ref_c, ref_d;
   logic [7:0] rdata, d;
   logic [3:0] pe;
   logic [6:0] bias;
   logic req_valid;
   ccor_pkg::ccor_req_s req;
   ccor_pkg::ccor_pll_ctrl_s pctl;
   int err_total = 0, comparisons = 0;
   logic [6:0] ra [5] = '{ccor_pkg::ADDR_OSCILLATOR_BIAS_LEVEL, A_PE, A_TRG, A_OVR, 7'h10};
   logic [7:0] rv [5] = '{8'h4f, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ov [5] = '{8'h80, 8'hbf, 8'ha9, 8'h82, 8'h95};
   always #50 clk = ~clk;
   always @(posedge clk) #1 pref = ~pref;
   ccor_host host (.clk(clk), .req(req), .req_valid(req_valid), .rdata(rdata));
   ccor_regs dut (.clk(clk), .rst(rst), .clk_en(clk_en), .req(req),
      .req_valid(req_valid), .rdata(rdata), .pll_enable_pin(en_p),
      .ref_select_pin(se_p), .clock_config_pin_a(cfg_a), .clock_config_pin_b(cfg_b),
      .receiver_reference_clock(rx), .timestamp_input(ts), .serializer_reinit(reinit),
      .pll_reference_clock(pref), .lane_preemphasis(pe), .oscillator_bias_level(bias),
      .trigger_output_pin(trig), .trigger_output_enable(trig_en), .pll_ctrl(pctl),
      .divided_ref_out_c(ref_c), .divided_ref_out_d(ref_d));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // A missing edge gives a period far off the mark, so a hang still counts.
   task automatic period(input logic [7:0] e);
      int t0, k;
      logic p;
      t0 = -1;
      p = trig;
      for (k = 0; k < 300; k++) begin
         @(posedge clk) #1;
         if (!p && trig === 1'b1) begin
            if (t0 >= 0) break;
            t0 = k;
         end
         p = trig;
      end
      chk("trigger period", 8'(k - t0), e);
   endtask
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 0;
      foreach (ra[i]) begin
         host.rd(ra[i], d);
         chk("reset value", d, rv[i]);
      end
      host.wr(ccor_pkg::ADDR_OSCILLATOR_BIAS_LEVEL, {1'b0, ccor_pkg::OSCILLATOR_BIAS_LEVEL_RECOMMENDED});
      chk("bias", {1'b0, bias}, 8'h4a);
      host.wr(A_PE, 8'h0a);
      chk("preemphasis", {4'h0, pe}, 8'h0a);
      clk_en = 0;
      host.wr(A_PE, 8'h05);
      clk_en = 1;
      host.rd(A_PE, d);
      chk("frozen write", d, 8'h0a);
      for (int m = 0; m < 3; m++) begin
         host.wr(A_TRG, 8'(m));
         host.wr(A_TRG, 8'(m) | 8'h80);
         chk("trigger enable", {7'h0, trig_en}, 8'h01);
         period(8'(16 << m));
         for (int k = 0; k < 100 && trig !== 1'b1; k++) @(posedge clk) #1;
         chk("trigger high", {7'h0, trig}, 8'h01);
         reinit = 1;
         @(posedge clk) #1 reinit = 0;
         repeat (2) @(posedge clk) #1;
         chk("reinit", {7'h0, trig}, 8'h00);
         host.wr(A_TRG, 8'(m));
      end
      host.wr(A_TRG, 8'h02);
      host.wr(A_TRG, 8'h03);
      host.wr(A_TRG, 8'h83);
      ts = 1;
      repeat (3) @(posedge clk) #1;
      chk("timestamp", {7'h0, trig}, 8'h01);
      host.wr(A_TRG, 8'h03);
      repeat (3) @(posedge clk) #1;
      chk("trigger off", {7'h0, trig}, 8'h00);
      host.wr(A_OVR, 8'h3f);
      chk("pin mode", {2'b0, pctl}, 8'h2a);
      foreach (ov[i]) begin
         host.wr(A_OVR, ov[i]);
         chk("override", {2'b0, pctl},
             {2'b0, ov[i][0], ov[i][1], ov[i][3:2], ov[i][5:4]});
      end
      repeat (3) begin
         @(posedge clk) #2;
         chk("refout c", {7'h0, ref_c}, {7'h0, pref});
         chk("refout d pass", {7'h0, ref_d}, {7'h0, pref});
      end
      host.wr(A_OVR, 8'hb0);
      repeat (6) begin
         @(posedge clk) #2;
         chk("refout d", {7'h0, ref_d}, 8'h00);
      end
      // A second reset mid-run must bring back the defaults and pin control.
      @(posedge clk) #1 rst = 1;
      @(posedge clk) #1 rst = 0;
      host.rd(ccor_pkg::ADDR_OSCILLATOR_BIAS_LEVEL, d);
      chk("bias after reset", d, ccor_pkg::RST_OSCILLATOR_BIAS_LEVEL);
      chk("pins after reset", {2'b0, pctl}, 8'h2a);
      end_of_test();
   end
endmodule
`default_nettype wire
